// ===== hdl/lcd_timing_regs.vh
// Purpose: Constants for the panel timing register block
// Assumes: Register index times four gives the AHB byte address
// Notes: Definitions only
`ifndef LCD_TIMING_REGS_VH
`define LCD_TIMING_REGS_VH

// ****************************************
// Register indices
// ****************************************
`define LCD_IDX_MODE 8'h03
`define LCD_IDX_HSIZE 8'h04
`define LCD_IDX_VSIZE_LO 8'h05
`define LCD_IDX_VSIZE_HI 8'h06
`define LCD_IDX_LP_START 8'h07
`define LCD_IDX_HBLANK 8'h08
`define LCD_IDX_FP_START 8'h09
`define LCD_IDX_VBLANK 8'h0A
`define LCD_IDX_IRQ_STATUS 8'h20
`define LCD_IDX_IRQ_MASK 8'h21

// ****************************************
// Field positions
// ****************************************
`define LCD_MODE_AM_BIT 7
`define LCD_VBLANK_STAT_BIT 7
`define LCD_EV_VBLANK 0
`define LCD_EV_FRAME 1
`define LCD_EV_LINE 2
`define LCD_EV_COUNT 3

// ****************************************
// Reset values and codes
// ****************************************
`define LCD_PSAVE_SLEEP 2'h0
`define LCD_PSAVE_NORMAL 2'h3
`define LCD_RST_HSIZE 7'h03
`define LCD_RST_VSIZE 10'h000
`define LCD_RST_LP_START 5'h00
`define LCD_RST_HBLANK 5'h00
`define LCD_RST_FP_START 6'h01
`define LCD_RST_VBLANK 6'h01

// ****************************************
// Timing counts
// ****************************************
`define LCD_HBLANK_ADD 8'h04
`define LCD_LP_ADD 8'h02
`define LCD_UNIT_LAST 3'h7

`endif

// ===== hdl/lcd_ahb_front.v
// Purpose: AHB-Lite slave front end for the timing registers
// Assumes: Single whole-word transfers, always OKAY
// Notes: Writes zero wait, reads one wait state
`timescale 1ns/100ps
`default_nettype none
module lcd_ahb_front (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_hsel,
  input wire [31:0] i_haddr,
  input wire [1:0] i_htrans,
  input wire i_hwrite,
  input wire i_hready,
  input wire [31:0] i_rd_data,
  output reg [31:0] o_hrdata,
  output wire o_hreadyout,
  output wire o_wr_en,
  output wire o_hit,
  output wire [7:0] o_idx
);

  reg pend_wr;
  reg pend_rd;
  reg rd_done;
  reg [31:0] addr;

  // Read waits one cycle so data comes from a flop
  assign o_hreadyout = ~(pend_rd & ~rd_done);
  assign o_wr_en = pend_wr;
  assign o_hit = (addr[31:10] == 22'h000000) && (addr[1:0] == 2'h0);
  assign o_idx = addr[9:2];

  // ****************************************
  // Address phase capture and read data
  // ****************************************
  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      pend_wr <= 1'b0;
      pend_rd <= 1'b0;
      rd_done <= 1'b0;
      addr <= 32'h00000000;
      o_hrdata <= 32'h00000000;
    end
    else if (o_hreadyout && i_hready)
    begin
      pend_wr <= i_hsel & i_htrans[1] & i_hwrite;
      pend_rd <= i_hsel & i_htrans[1] & ~i_hwrite;
      rd_done <= 1'b0;
      addr <= i_haddr;
    end
    else if (!o_hreadyout)
    begin
      o_hrdata <= i_rd_data;
      rd_done <= 1'b1;
    end
  end

endmodule // lcd_ahb_front
`default_nettype wire

// ===== hdl/lcd_irq_bank.v
// Purpose: Sticky event status with mask and one level interrupt
// Assumes: Write one to a status bit clears it
// Notes: A set in the clearing cycle wins
`timescale 1ns/100ps
`default_nettype none
`include "lcd_timing_regs.vh"
module lcd_irq_bank (
  input wire i_clk,
  input wire i_rst_n,
  input wire [`LCD_EV_COUNT-1:0] i_set,
  input wire i_clr_wr,
  input wire i_mask_wr,
  input wire [`LCD_EV_COUNT-1:0] i_wdata,
  output reg [`LCD_EV_COUNT-1:0] o_status,
  output reg [`LCD_EV_COUNT-1:0] o_mask,
  output reg o_irq
);

  genvar b;

  // ****************************************
  // Per event sticky bit and mask bit
  // ****************************************
  generate
    for (b = 0; b < `LCD_EV_COUNT; b = b + 1)
    begin : g_ev
      always @(posedge i_clk)
      begin
        if (!i_rst_n)
        begin
          o_status[b] <= 1'b0;
          o_mask[b] <= 1'b0;
        end
        else
        begin
          o_status[b] <= i_set[b] | (o_status[b] & ~(i_clr_wr & i_wdata[b]));
          if (i_mask_wr)
            o_mask[b] <= i_wdata[b];
        end
      end
    end
  endgenerate

  // Registered interrupt level
  always @(posedge i_clk)
  begin
    if (!i_rst_n)
      o_irq <= 1'b0;
    else
      o_irq <= |(o_status & o_mask);
  end

endmodule // lcd_irq_bank
`default_nettype wire

// ===== hdl/lcd_panel_timing_regs.v
// Purpose: Panel geometry registers and line/frame sync timing
// Assumes: One pixel per I_MCLK cycle, 8-pixel timing units
// Notes: Registers reached over AHB-Lite at index times four
// Functional notes
// - Power-save field: 00 sleep, 11 normal
// - Ten-bit vertical size is line count minus one
// - Line pulse at (start+2)*8 after data
// - Horizontal blank lasts (field+4)*8 pixels
// - Frame pulse follows last line by field lines
// - Pulse start fields used only in active-matrix
// - Status bit high throughout vertical blank
// - Vertical blank lasts field count lines
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "lcd_timing_regs.vh"
module lcd_panel_timing_regs (
  input wire I_MCLK,
  input wire I_RST_N,
  input wire I_HSEL,
  input wire [31:0] I_HADDR,
  input wire [1:0] I_HTRANS,
  input wire I_HWRITE,
  input wire [2:0] I_HSIZE,
  input wire [31:0] I_HWDATA,
  input wire I_HREADY,
  output wire [31:0] O_HRDATA,
  output wire O_HREADYOUT,
  output wire O_HRESP,
  output reg O_LINE_SYNC_PULSE,
  output reg O_FRAME_SYNC_PULSE,
  output reg O_DISPLAY_ACTIVE,
  output reg O_POWER_SAVE,
  output wire O_IRQ
);

  // ****************************************
  // Declarations
  // ****************************************
  wire wr_en;
  wire hit;
  wire [7:0] idx;
  reg [31:0] rd_data;
  reg [1:0] power_save_mode;
  reg active_matrix_mode;
  reg [6:0] horizontal_size;
  reg [9:0] vertical_size;
  reg [4:0] line_pulse_start;
  reg [4:0] horizontal_blank_period;
  reg [5:0] frame_pulse_start;
  reg [5:0] vertical_blank_period;
  reg [6:0] sh_hsize;
  reg [4:0] sh_hblank;
  reg [4:0] sh_lp_start;
  reg sh_am;
  reg [9:0] sh_vsize;
  reg [5:0] sh_vblank;
  reg [5:0] sh_fp_start;
  reg [2:0] pix;
  reg [7:0] unit;
  reg [10:0] line;
  reg vblank_status;
  wire running;
  wire [7:0] act_units;
  wire [7:0] line_units;
  wire [10:0] act_lines;
  wire [10:0] frame_lines;
  wire line_end;
  wire frame_end;
  wire in_hblank;
  wire in_vblank;
  wire [7:0] lp_unit;
  wire [10:0] fp_line;
  wire lp_now;
  wire fp_now;
  wire [`LCD_EV_COUNT-1:0] events;
  wire [`LCD_EV_COUNT-1:0] irq_status;
  wire [`LCD_EV_COUNT-1:0] irq_mask;
  wire clr_wr;
  wire mask_wr;

  // ****************************************
  // Bus front end and interrupt bank
  // ****************************************
  lcd_ahb_front u_front (
    .i_clk(I_MCLK),
    .i_rst_n(I_RST_N),
    .i_hsel(I_HSEL),
    .i_haddr(I_HADDR),
    .i_htrans(I_HTRANS),
    .i_hwrite(I_HWRITE),
    .i_hready(I_HREADY),
    .i_rd_data(rd_data),
    .o_hrdata(O_HRDATA),
    .o_hreadyout(O_HREADYOUT),
    .o_wr_en(wr_en),
    .o_hit(hit),
    .o_idx(idx)
  );

  // Status clear and mask writes
  assign clr_wr = wr_en & hit & (idx == `LCD_IDX_IRQ_STATUS);
  assign mask_wr = wr_en & hit & (idx == `LCD_IDX_IRQ_MASK);
  assign O_HRESP = 1'b0;

  lcd_irq_bank u_irq (
    .i_clk(I_MCLK),
    .i_rst_n(I_RST_N),
    .i_set(events),
    .i_clr_wr(clr_wr),
    .i_mask_wr(mask_wr),
    .i_wdata(I_HWDATA[`LCD_EV_COUNT-1:0]),
    .o_status(irq_status),
    .o_mask(irq_mask),
    .o_irq(O_IRQ)
  );

  // ****************************************
  // Register writes
  // ****************************************
  always @(posedge I_MCLK)
  begin
    if (!I_RST_N)
    begin
      power_save_mode <= `LCD_PSAVE_SLEEP;
      active_matrix_mode <= 1'b0;
      horizontal_size <= `LCD_RST_HSIZE;
      vertical_size <= `LCD_RST_VSIZE;
      line_pulse_start <= `LCD_RST_LP_START;
      horizontal_blank_period <= `LCD_RST_HBLANK;
      frame_pulse_start <= `LCD_RST_FP_START;
      vertical_blank_period <= `LCD_RST_VBLANK;
    end
    else if (wr_en && hit)
    begin
      case (idx)
        `LCD_IDX_MODE:
        begin
          power_save_mode <= I_HWDATA[1:0];
          active_matrix_mode <= I_HWDATA[`LCD_MODE_AM_BIT];
        end
        `LCD_IDX_HSIZE: horizontal_size <= I_HWDATA[6:0];
        `LCD_IDX_VSIZE_LO: vertical_size[7:0] <= I_HWDATA[7:0];
        `LCD_IDX_VSIZE_HI: vertical_size[9:8] <= I_HWDATA[1:0];
        `LCD_IDX_LP_START: line_pulse_start <= I_HWDATA[4:0];
        `LCD_IDX_HBLANK: horizontal_blank_period <= I_HWDATA[4:0];
        `LCD_IDX_FP_START: frame_pulse_start <= I_HWDATA[5:0];
        `LCD_IDX_VBLANK: vertical_blank_period <= I_HWDATA[5:0];
        default: power_save_mode <= power_save_mode;
      endcase
    end
  end

  // ****************************************
  // Register read mux
  // ****************************************
  always @*
  begin
    rd_data = 32'h00000000;
    if (hit)
    begin
      case (idx)
        `LCD_IDX_MODE:
          rd_data = {24'h000000, active_matrix_mode, 5'h00,
                     power_save_mode};
        `LCD_IDX_HSIZE: rd_data = {25'h0000000, horizontal_size};
        `LCD_IDX_VSIZE_LO: rd_data = {24'h000000, vertical_size[7:0]};
        `LCD_IDX_VSIZE_HI: rd_data = {30'h00000000, vertical_size[9:8]};
        `LCD_IDX_LP_START: rd_data = {27'h0000000, line_pulse_start};
        `LCD_IDX_HBLANK: rd_data = {27'h0000000, horizontal_blank_period};
        `LCD_IDX_FP_START: rd_data = {26'h0000000, frame_pulse_start};
        `LCD_IDX_VBLANK:
          rd_data = {24'h000000, vblank_status, 1'b0,
                     vertical_blank_period};
        `LCD_IDX_IRQ_STATUS: rd_data = {29'h00000000, irq_status};
        `LCD_IDX_IRQ_MASK: rd_data = {29'h00000000, irq_mask};
        default: rd_data = 32'h00000000;
      endcase
    end
  end

  // ****************************************
  // Geometry from boundary-sampled values
  // ****************************************
  assign running = (power_save_mode == `LCD_PSAVE_NORMAL);
  assign act_units = {1'b0, sh_hsize} + 8'h01;
  assign line_units = act_units + {3'h0, sh_hblank}
                      + `LCD_HBLANK_ADD;
  assign act_lines = {1'b0, sh_vsize} + 11'h001;
  assign frame_lines = act_lines + {5'h00, sh_vblank};
  assign line_end = (pix == `LCD_UNIT_LAST)
                    && (unit == line_units - 8'h01);
  assign frame_end = line_end && (line == frame_lines - 11'h001);
  assign in_hblank = (unit >= act_units);
  assign in_vblank = (line >= act_lines);

  // Pulse positions; start fields only in active-matrix
  assign lp_unit = sh_am ? act_units + {3'h0, sh_lp_start} + `LCD_LP_ADD
                   : act_units;
  assign fp_line = sh_am ? act_lines + {5'h00, sh_fp_start} - 11'h001
                   : act_lines;
  assign lp_now = running && (unit == lp_unit);
  assign fp_now = running && (sh_vblank != 6'h00) && (line == fp_line);

  // ****************************************
  // Shadow registers
  // ****************************************
  always @(posedge I_MCLK)
  begin
    if (!I_RST_N)
    begin
      sh_hsize <= `LCD_RST_HSIZE;
      sh_hblank <= `LCD_RST_HBLANK;
      sh_lp_start <= `LCD_RST_LP_START;
      sh_am <= 1'b0;
      sh_vsize <= `LCD_RST_VSIZE;
      sh_vblank <= `LCD_RST_VBLANK;
      sh_fp_start <= `LCD_RST_FP_START;
    end
    else
    begin
      // Horizontal values at line end, or every cycle while not running
      if (!running || line_end)
      begin
        sh_hsize <= horizontal_size;
        sh_hblank <= horizontal_blank_period;
        sh_lp_start <= line_pulse_start;
      end
      // Vertical values and panel type at frame end, or every cycle while not running
      if (!running || frame_end)
      begin
        sh_am <= active_matrix_mode;
        sh_vsize <= vertical_size;
        sh_vblank <= vertical_blank_period;
        sh_fp_start <= frame_pulse_start;
      end
    end
  end

  // ****************************************
  // Pixel, unit and line counters
  // ****************************************
  always @(posedge I_MCLK)
  begin
    if (!I_RST_N || !running)
    begin
      pix <= 3'h0;
      unit <= 8'h00;
      line <= 11'h000;
    end
    else
    begin
      pix <= pix + 3'h1;
      if (pix == `LCD_UNIT_LAST)
      begin
        if (line_end)
        begin
          unit <= 8'h00;
          if (frame_end)
            line <= 11'h000;
          else
            line <= line + 11'h001;
        end
        else
          unit <= unit + 8'h01;
      end
    end
  end

  // ****************************************
  // Registered panel outputs and vblank status
  // ****************************************
  always @(posedge I_MCLK)
  begin
    if (!I_RST_N)
    begin
      O_LINE_SYNC_PULSE <= 1'b0;
      O_FRAME_SYNC_PULSE <= 1'b0;
      O_DISPLAY_ACTIVE <= 1'b0;
      O_POWER_SAVE <= 1'b1;
      vblank_status <= 1'b0;
    end
    else
    begin
      O_LINE_SYNC_PULSE <= lp_now;
      O_FRAME_SYNC_PULSE <= fp_now;
      O_DISPLAY_ACTIVE <= running && !in_hblank && !in_vblank;
      O_POWER_SAVE <= !running;
      vblank_status <= running && in_vblank;
    end
  end

  // Leading edges raise sticky events
  assign events[`LCD_EV_VBLANK] = running && in_vblank && !vblank_status;
  assign events[`LCD_EV_FRAME] = fp_now && !O_FRAME_SYNC_PULSE;
  assign events[`LCD_EV_LINE] = lp_now && !O_LINE_SYNC_PULSE;

endmodule // lcd_panel_timing_regs
`default_nettype wire

// ===== test/lcd_timing_monitor.sv
// Purpose: Port checks for the panel timing block
// Assumes: Sees only the top ports, one clock
// Notes: Bound from tb_top
`timescale 1ns/100ps
`default_nettype none
module lcd_timing_monitor (
  input wire logic I_MCLK,
  input wire logic I_RST_N,
  input wire logic I_HSEL,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic I_HREADY,
  input wire logic O_HREADYOUT,
  input wire logic O_LINE_SYNC_PULSE,
  input wire logic O_FRAME_SYNC_PULSE,
  input wire logic O_DISPLAY_ACTIVE,
  input wire logic O_POWER_SAVE,
  input wire logic O_HRESP
);
  logic prev;
  logic full;
  logic [11:0] run;
  // Length of the current active or blank run
  always @(posedge I_MCLK)
  begin
    prev <= O_DISPLAY_ACTIVE;
    run <= (O_DISPLAY_ACTIVE == prev) ? run + 12'h001 : 12'h001;
    if (!I_RST_N || O_POWER_SAVE)
      full <= 1'b0;
    else if (O_DISPLAY_ACTIVE != prev)
      full <= 1'b1;
  end
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RST_N);
  sequence bus_taken;
    I_HSEL && I_HTRANS[1] && I_HREADY && O_HREADYOUT;
  endsequence
  sequence one_wait;
    !O_HREADYOUT ##1 O_HREADYOUT;
  endsequence
  read_wait_a: assert property (
    bus_taken and !I_HWRITE |=> one_wait) else $error("read wait wrong");
  write_nowait_a: assert property (
    bus_taken and I_HWRITE |=> O_HREADYOUT) else $error("write stalled");
  line_width_a: assert property (
    disable iff (!I_RST_N || O_POWER_SAVE) $rose(O_LINE_SYNC_PULSE) |->
    O_LINE_SYNC_PULSE[*8] ##1 !O_LINE_SYNC_PULSE) else $error("line width");
  line_blank_a: assert property (
    O_LINE_SYNC_PULSE |-> !O_DISPLAY_ACTIVE) else $error("line in data");
  frame_blank_a: assert property (
    O_FRAME_SYNC_PULSE |-> !O_DISPLAY_ACTIVE) else $error("frame in data");
  active_span_a: assert property (
    full && prev && !O_DISPLAY_ACTIVE |-> run[2:0] == 3'h0 && run >= 12'd32)
    else $error("active span wrong");
  blank_span_a: assert property (
    full && !prev && O_DISPLAY_ACTIVE |-> run[2:0] == 3'h0 && run >= 12'd32)
    else $error("blank span wrong");
  psave_quiet_a: assert property (
    O_POWER_SAVE[*3] |-> !O_LINE_SYNC_PULSE && !O_FRAME_SYNC_PULSE)
    else $error("pulse in power save");
  okay_resp_a: assert property (
    !O_HRESP) else $error("error response");
endmodule // lcd_timing_monitor
`default_nettype wire

// ===== test/lcd_panel_model.sv
// Purpose: Panel side that measures sync timing
// Assumes: One pixel per clock
// Notes: Counts in clocks, lines
`timescale 1ns/100ps
`default_nettype none
module lcd_panel_model (
  input wire logic i_clk,
  input wire logic i_line,
  input wire logic i_frame,
  input wire logic i_active,
  output logic [11:0] o_line_per,
  output logic [11:0] o_lp_delay,
  output logic [11:0] o_fp_delay,
  output logic [11:0] o_lines
);
  logic pa = 1'b0;
  logic pl = 1'b0;
  logic pf = 1'b0;
  logic armed = 1'b0;
  logic [11:0] since_a = 12'h000;
  logic [11:0] since_l = 12'h000;
  logic [11:0] nl = 12'h000;
  wire fell_a = pa && !i_active;
  wire rose_l = i_line && !pl;
  // Delays from end of data, line period, lines per frame
  always @(posedge i_clk)
  begin
    pa <= i_active;
    pl <= i_line;
    pf <= i_frame;
    since_a <= fell_a ? 12'h001 : since_a + 12'h001;
    since_l <= rose_l ? 12'h001 : since_l + 12'h001;
    if (fell_a)
      armed <= 1'b1;
    if (rose_l)
    begin
      o_line_per <= since_l;
      nl <= nl + 12'h001;
      armed <= 1'b0;
      if (armed || fell_a)
        o_lp_delay <= fell_a ? 12'h000 : since_a;
    end
    if (i_frame && !pf)
    begin
      o_fp_delay <= since_a;
      o_lines <= nl;
      nl <= {11'h000, rose_l};
    end
  end
endmodule // lcd_panel_model
`default_nettype wire

// ===== test/tb_top.sv
// Purpose: Register and sync timing tests
// Assumes: AHB-Lite master, index times four
// Notes: Panel model measures the link
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  wire [31:0] hrdata;
  wire hready, line_p, frame_p, active, psave, irq;
  wire [11:0] lper, lpd, fpd, nlines;
  logic [31:0] rd;
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [7:0] ridx [11] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
    8'h09, 8'h0A, 8'h21, 8'h40, 8'h20};
  logic [7:0] rrst [11] = '{0, 8'h03, 0, 0, 0, 0, 8'h01, 8'h01, 0, 0, 0};
  logic [7:0] rful [11] = '{0, 8'h7F, 8'hFF, 8'h03, 8'h1F, 8'h1F, 8'h3F,
    8'h3F, 8'h07, 0, 0};
  logic [7:0] rcfg [11] = '{0, 8'h03, 8'h01, 0, 8'h01, 8'h01, 8'h02,
    8'h03, 0, 0, 0};
  lcd_panel_timing_regs i_lcd_panel_timing_regs (.I_MCLK(clk),
    .I_RST_N(rst_n), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
    .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready),
    .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(),
    .O_LINE_SYNC_PULSE(line_p), .O_FRAME_SYNC_PULSE(frame_p),
    .O_DISPLAY_ACTIVE(active), .O_POWER_SAVE(psave), .O_IRQ(irq));
  lcd_panel_model i_lcd_panel_model (.i_clk(clk), .i_line(line_p),
    .i_frame(frame_p), .i_active(active), .o_line_per(lper),
    .o_lp_delay(lpd), .o_fp_delay(fpd), .o_lines(nlines));
  // Clock and hang guard
  initial forever #50 clk = ~clk;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      errors++;
      print_verdict();
    end
  end
  // One single AHB transfer, ready sampled at rising edges, read data in rd
  task automatic xfer(input logic w, input logic [7:0] idx,
    input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 11; i++)
    begin
      xfer(1'b0, ridx[i], 32'h0);
      chk(ridx[i] == 8'h0A ? rd & 32'h3F : rd, {24'h0, rrst[i]});
    end
    for (int i = 1; i < 10; i++)
      xfer(1'b1, ridx[i], 32'hFFFFFFFF);
    for (int i = 1; i < 10; i++)
    begin
      xfer(1'b0, ridx[i], 32'h0);
      chk(ridx[i] == 8'h0A ? rd & 32'h3F : rd, {24'h0, rful[i]});
    end
    for (int i = 1; i < 9; i++)
      xfer(1'b1, ridx[i], {24'h0, rcfg[i]});
    $display("test registers done");
    for (int c = 0; c < 4; c++)
    begin
      xfer(1'b1, 8'h03, 32'h7C | c);
      settle();
      chk({31'h0, psave}, {31'h0, c != 3});
      xfer(1'b0, 8'h03, 32'h0);
      chk(rd, c);
    end
    repeat (3) @(posedge frame_p);
    chk(lper, 72);
    chk(lpd, 0);
    chk(fpd, 40);
    chk(nlines, 5);
    @(posedge active);
    xfer(1'b0, 8'h0A, 32'h0);
    chk(rd & 32'h80, 0);
    @(posedge frame_p);
    xfer(1'b0, 8'h0A, 32'h0);
    chk(rd & 32'h80, 32'h80);
    $display("test passive done");
    xfer(1'b1, 8'h03, 32'h83);
    repeat (3) @(posedge frame_p);
    chk(lper, 72);
    chk(lpd, 24);
    chk(fpd, 112);
    chk(nlines, 5);
    $display("test active done");
    @(posedge frame_p);
    xfer(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h7);
    settle();
    chk({31'h0, irq}, 0);
    xfer(1'b1, 8'h20, 32'h3);
    xfer(1'b0, 8'h20, 32'h0);
    chk(rd & 32'h3, 0);
    xfer(1'b1, 8'h21, 32'h1);
    settle();
    chk({31'h0, irq}, 0);
    @(posedge frame_p);
    settle();
    chk({31'h0, irq}, 1);
    xfer(1'b1, 8'h21, 32'h0);
    settle();
    chk({31'h0, irq}, 0);
    $display("test interrupt done");
    // Width change mid-line lands at a line end; monitor guards the spans
    xfer(1'b1, 8'h04, 32'h4);
    repeat (3) @(posedge frame_p);
    chk(lper, 80);
    chk(lpd, 24);
    $display("test resize done");
    print_verdict();
  end
endmodule // tb_top
bind lcd_panel_timing_regs lcd_timing_monitor i_lcd_timing_monitor (
  .I_MCLK(I_MCLK), .I_RST_N(I_RST_N), .I_HSEL(I_HSEL),
  .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE), .I_HREADY(I_HREADY),
  .O_HREADYOUT(O_HREADYOUT), .O_LINE_SYNC_PULSE(O_LINE_SYNC_PULSE),
  .O_FRAME_SYNC_PULSE(O_FRAME_SYNC_PULSE),
  .O_DISPLAY_ACTIVE(O_DISPLAY_ACTIVE), .O_POWER_SAVE(O_POWER_SAVE),
  .O_HRESP(O_HRESP));
`default_nettype wire
